// ==== rtl/uic_ctrl.sv ====
/*
 * top of the interrupt and low-power control block: avalon-mm register
 * slave, first control register, enables, flag and merge instances.
 * assumes event pulses, power state and kernel clock select are on clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module uic_ctrl
	import uic_pkg::*;
#(
	parameter bit HAS_SMARTCARD = 1'b1,
	parameter bit HAS_TIMEOUT   = 1'b1,
	parameter bit HAS_STOP_WAKE = 1'b1
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// avalon-mm slave
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// events from transceiver core
	input  wire logic [14:0] evt_set_i,
	// power and clock state
	input  wire logic        sleep_i,
	input  wire logic        stop_i,
	input  wire logic [1:0]  kclk_sel_i,
	// configuration to transceiver core
	output logic             unit_enable_o,
	output logic             tx_enable_o,
	output logic             rx_enable_o,
	output logic      [3:0]  data_bits_o,
	// to interrupt and power controller
	output logic             irq_o,
	output logic             wake_req_o
);
	localparam logic [31:0] FORCE_ZERO =
		({31'h0, ~HAS_SMARTCARD} << B_END_OF_BLOCK_IRQ_ENABLE) |
		({31'h0, ~HAS_TIMEOUT} << B_RX_TIMEOUT_IRQ_ENABLE) |
		({31'h0, ~HAS_STOP_WAKE} << B_STOP_WAKE_ENABLE);

	uic_evt_if ev ();

	logic        ack_r;
	logic        rd_acc;
	logic        wr_acc;
	logic [31:0] be_mask;
	logic [31:0] readdata_r;
	logic [31:0] rd_nxt;
	logic [31:0] cr1_r;
	logic [31:0] cr1_nxt;
	logic [31:0] cr1_wmask;
	logic [3:0]  irqc_r;
	logic [3:0]  irqc_nxt;
	logic [14:0] clr_vec;
	logic [3:0]  data_bits_r;
	logic [3:0]  data_bits_nxt;
	logic        kclk_ok;

	// bus handshake: one wait cycle, then accept
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
	assign rd_acc = avs_read_i & ack_r;
	assign wr_acc = avs_write_i & ack_r;
	assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
			  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
		end
	end

	// read data, zero for unmapped offsets
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (avs_address_i)
			OFS_CONTROL_ONE: rd_nxt = cr1_r;
			OFS_IRQ_CTRL:    rd_nxt = {28'h000_0000, irqc_r};
			OFS_STATUS:      rd_nxt = {17'h0_0000, ev.flags};
			default:         rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			readdata_r <= 32'h0000_0000;
		end else if (avs_read_i && !ack_r) begin
			readdata_r <= rd_nxt;
		end
	end

	assign avs_readdata_o = readdata_r;

	// control_one: locked fields writable only while unit disabled
	always_comb begin
		cr1_wmask = be_mask & CONTROL_ONE_WMASK & ~FORCE_ZERO;
		if (cr1_r[B_UE]) begin
			cr1_wmask = cr1_wmask & ~CONTROL_ONE_LOCK;
		end
		cr1_nxt = cr1_r;
		if (wr_acc && avs_address_i == OFS_CONTROL_ONE) begin
			cr1_nxt = (cr1_r & ~cr1_wmask) | (avs_writedata_i & cr1_wmask);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cr1_r <= CONTROL_ONE_RESET;
		end else begin
			cr1_r <= cr1_nxt;
		end
	end

	// second enable register
	always_comb begin
		irqc_nxt = irqc_r;
		if (wr_acc && avs_address_i == OFS_IRQ_CTRL && avs_byteenable_i[0]) begin
			irqc_nxt = avs_writedata_i[3:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irqc_r <= IRQ_CTRL_RESET;
		end else begin
			irqc_r <= irqc_nxt;
		end
	end

	// write one to clear flags
	always_comb begin
		clr_vec = 15'h0000;
		if (wr_acc && avs_address_i == OFS_FLAG_CLR) begin
			clr_vec = avs_writedata_i[14:0] & be_mask[14:0];
		end
	end

	// word length decode
	always_comb begin
		case ({cr1_r[B_M1], cr1_r[B_M0]})
			WLEN_8:  data_bits_nxt = DBITS_8;
			WLEN_9:  data_bits_nxt = DBITS_9;
			WLEN_7:  data_bits_nxt = DBITS_7;
			default: data_bits_nxt = DBITS_8;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_bits_r <= DBITS_8;
		end else begin
			data_bits_r <= data_bits_nxt;
		end
	end

	assign data_bits_o   = data_bits_r;
	assign unit_enable_o = cr1_r[B_UE];
	assign tx_enable_o   = cr1_r[B_TE] & cr1_r[B_UE];
	assign rx_enable_o   = cr1_r[B_RE] & cr1_r[B_UE];

	// stop wakeup needs its enable and an allowed kernel clock
	assign kclk_ok = (kclk_sel_i == KCLK_FAST_OSC) || (kclk_sel_i == KCLK_SLOW_EXT);

	// per-flag enables onto the carrier
	assign ev.set     = evt_set_i;
	assign ev.clr     = clr_vec;
	assign ev.ue      = cr1_r[B_UE];
	assign ev.err_en  = irqc_r[B_EIE];
	assign ev.stop    = stop_i;
	assign ev.sleep   = sleep_i;
	assign ev.wake_ok = cr1_r[B_STOP_WAKE_ENABLE] & kclk_ok;
	assign ev.en[F_PE]    = cr1_r[B_PARITY_ERROR_IRQ_ENABLE];
	assign ev.en[F_FE]    = 1'b0;
	assign ev.en[F_NF]    = 1'b0;
	assign ev.en[F_ORE]   = cr1_r[B_RXIE];
	assign ev.en[F_IDLE]  = cr1_r[B_IDLE_LINE_IRQ_ENABLE];
	assign ev.en[F_RX_NOT_EMPTY_FLAG]  = cr1_r[B_RXIE];
	assign ev.en[F_TC]    = cr1_r[B_TRANSFER_COMPLETE_IRQ_ENABLE];
	assign ev.en[F_TXE]   = cr1_r[B_TX_EMPTY_IRQ_ENABLE];
	assign ev.en[F_LBD]   = 1'b0;
	assign ev.en[F_CTS]   = irqc_r[B_CLEAR_TO_SEND_IRQ_ENABLE];
	assign ev.en[F_RTO]   = cr1_r[B_RX_TIMEOUT_IRQ_ENABLE];
	assign ev.en[F_EOB]   = cr1_r[B_END_OF_BLOCK_IRQ_ENABLE];
	assign ev.en[F_CM]    = cr1_r[B_CHAR_MATCH_IRQ_ENABLE];
	assign ev.en[F_WUF]   = irqc_r[B_WAKEUP_IRQ_ENABLE];
	assign ev.en[F_COMPLETE_BEFORE_GUARD_FLAG] = irqc_r[B_COMPLETE_BEFORE_GUARD_IRQ_ENABLE];

	uic_flags u_flags (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ev      (ev.flag_mp)
	);

	uic_irq u_irq (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ev      (ev.irq_mp)
	);

	assign irq_o      = ev.irq;
	assign wake_req_o = ev.wake;

	// checks
	logic [14:0] chk_req;
	logic        chk_other;
	assign chk_req   = ev.flags & ev.en;
	assign chk_other = (|(chk_req & ~(15'h0001 << F_WUF))) |
			   (irqc_r[B_EIE] & (|(ev.flags & FLAG_ERR_MASK)));

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_cr1_wr_locked;
		wr_acc && avs_address_i == OFS_CONTROL_ONE && cr1_r[B_UE];
	endsequence

	sequence s_cr1_wr_nine;
		wr_acc && avs_address_i == OFS_CONTROL_ONE && !cr1_r[B_UE] &&
		avs_byteenable_i == 4'hF && !avs_writedata_i[B_M1] && avs_writedata_i[B_M0];
	endsequence

	chk_len_locked: assert property (s_cr1_wr_locked |=> $stable(cr1_r[B_M1]))
		else $error("word length changed while enabled");

	chk_len_nine: assert property (s_cr1_wr_nine |=> ##1 data_bits_o == DBITS_9)
		else $error("nine bit word length not selected");

	chk_eob_forced: assert property (!HAS_SMARTCARD |-> !cr1_r[B_END_OF_BLOCK_IRQ_ENABLE])
		else $error("end of block enable not held at zero");

	chk_rto_forced: assert property (!HAS_TIMEOUT |-> avs_readdata_o[B_RX_TIMEOUT_IRQ_ENABLE] == 1'b0 ||
		!$past(avs_address_i == OFS_CONTROL_ONE))
		else $error("timeout enable read back nonzero");

	chk_disable_flags: assert property ($fell(cr1_r[B_UE]) |=> ev.flags == FLAG_DEFAULT)
		else $error("flags not defaulted on unit disable");

	chk_overrun_irq: assert property ((ev.flags[F_ORE] && cr1_r[B_RXIE]) |=> irq_o)
		else $error("overrun with receive enable gave no interrupt");

	chk_tx_sources: assert property ((ev.flags[F_TC] && cr1_r[B_TRANSFER_COMPLETE_IRQ_ENABLE]) ##1
		(ev.flags[F_TC] && cr1_r[B_TRANSFER_COMPLETE_IRQ_ENABLE]) |-> ##1 irq_o [*1])
		else $error("transfer complete level not held");

	chk_wuf_only_stop: assert property ((!stop_i && !chk_other) |=> !irq_o)
		else $error("wakeup flag interrupt outside stop");

	chk_err_common: assert property ((!irqc_r[B_EIE] && chk_req == 15'h0000) |=> !irq_o)
		else $error("error interrupt without common enable");

	chk_stop_gate: assert property ((stop_i && !(cr1_r[B_STOP_WAKE_ENABLE] && kclk_ok)) |=> !wake_req_o)
		else $error("stop wakeup without enable or allowed clock");

	chk_stop_rx: assert property ((stop_i && cr1_r[B_STOP_WAKE_ENABLE] && kclk_ok &&
		ev.flags[F_RX_NOT_EMPTY_FLAG] && cr1_r[B_RXIE]) |=> wake_req_o)
		else $error("receive not empty did not wake from stop");

	chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o)
		else $error("bus request not answered in one cycle");
endmodule : uic_ctrl
`default_nettype wire

// ==== rtl/uic_pkg.sv ====
/*
 * constants of the serial transceiver interrupt and low-power control block:
 * register offsets, field positions, reset values, flag layout.
 * assumes a 32-bit avalon-mm slave with byte addresses.
 */
// Behaviour
// - sleep keeps running; enabled interrupt wakes device
// - stop wakeup needs enable and fast/slow oscillator
// - stop wakeup via receive-not-empty or wakeup flag
// - transmit sources each gated by own enable
// - receive sources gated by own or shared enable
// - noise, overrun, framing use common error enable
// - all events except F_LBD merge onto one interrupt output
// - request only while flag and enable set
// - wakeup flag request only in stop state
// - word length 00=8, 01=9, 10=7 bits
// - bit 28 writable only while unit disabled
// - bit 27 enables end-of-block interrupt
// - end-of-block enable forced zero without smartcard
// - bit 26 timeout enable, zero without timeout
// - receive enable covers not-empty and overrun
// - unit disable resets flags, keeps configuration
package uic_pkg;

	// register byte offsets
	localparam logic [5:0] OFS_CONTROL_ONE = 6'h00;
	localparam logic [5:0] OFS_IRQ_CTRL    = 6'h08;
	localparam logic [5:0] OFS_STATUS      = 6'h1C;
	localparam logic [5:0] OFS_FLAG_CLR    = 6'h20;

	// control_one field positions
	localparam int B_UE     = 0;
	localparam int B_STOP_WAKE_ENABLE   = 1;
	localparam int B_RE     = 2;
	localparam int B_TE     = 3;
	localparam int B_IDLE_LINE_IRQ_ENABLE = 4;
	localparam int B_RXIE   = 5;
	localparam int B_TRANSFER_COMPLETE_IRQ_ENABLE   = 6;
	localparam int B_TX_EMPTY_IRQ_ENABLE  = 7;
	localparam int B_PARITY_ERROR_IRQ_ENABLE   = 8;
	localparam int B_M0     = 12;
	localparam int B_CHAR_MATCH_IRQ_ENABLE   = 14;
	localparam int B_RX_TIMEOUT_IRQ_ENABLE  = 26;
	localparam int B_END_OF_BLOCK_IRQ_ENABLE  = 27;
	localparam int B_M1     = 28;

	localparam logic [31:0] CONTROL_ONE_RESET = 32'h0000_0000;
	localparam logic [31:0] CONTROL_ONE_WMASK = 32'h1FFF_FFFF;
	localparam logic [31:0] CONTROL_ONE_LOCK  = 32'h13FF_9E00;

	// irq_ctrl field positions
	localparam int B_EIE     = 0;
	localparam int B_CLEAR_TO_SEND_IRQ_ENABLE   = 1;
	localparam int B_WAKEUP_IRQ_ENABLE   = 2;
	localparam int B_COMPLETE_BEFORE_GUARD_IRQ_ENABLE = 3;
	localparam logic [3:0] IRQ_CTRL_RESET = 4'h0;

	// flag positions in interrupt_status_reg
	localparam int NFLAG    = 15;
	localparam int F_PE     = 0;
	localparam int F_FE     = 1;
	localparam int F_NF     = 2;
	localparam int F_ORE    = 3;
	localparam int F_IDLE   = 4;
	localparam int F_RX_NOT_EMPTY_FLAG   = 5;
	localparam int F_TC     = 6;
	localparam int F_TXE    = 7;
	localparam int F_LBD    = 8;
	localparam int F_CTS    = 9;
	localparam int F_RTO    = 10;
	localparam int F_EOB    = 11;
	localparam int F_CM     = 12;
	localparam int F_WUF    = 13;
	localparam int F_COMPLETE_BEFORE_GUARD_FLAG  = 14;
	localparam logic [14:0] FLAG_DEFAULT = 15'h00C0;
	localparam logic [14:0] FLAG_ERR_MASK = 15'h000E;

	// kernel clock selection
	localparam logic [1:0] KCLK_PERIPH   = 2'h0;
	localparam logic [1:0] KCLK_SYSTEM   = 2'h1;
	localparam logic [1:0] KCLK_FAST_OSC = 2'h2;
	localparam logic [1:0] KCLK_SLOW_EXT = 2'h3;

	// word length codes and data bit counts
	localparam logic [1:0] WLEN_8 = 2'h0;
	localparam logic [1:0] WLEN_9 = 2'h1;
	localparam logic [1:0] WLEN_7 = 2'h2;
	localparam logic [3:0] DBITS_7 = 4'h7;
	localparam logic [3:0] DBITS_8 = 4'h8;
	localparam logic [3:0] DBITS_9 = 4'h9;

endpackage : uic_pkg

// ==== rtl/uic_evt_if.sv ====
/*
 * carrier between the control top, the flag store and the interrupt merge.
 * assumes all three sit on one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface uic_evt_if;
	logic [14:0] set;
	logic [14:0] clr;
	logic        ue;
	logic [14:0] flags;
	logic [14:0] en;
	logic        err_en;
	logic        stop;
	logic        sleep;
	logic        wake_ok;
	logic        irq;
	logic        wake;

	modport flag_mp (input set, clr, ue, output flags);
	modport irq_mp  (input flags, en, err_en, stop, sleep, wake_ok, output irq, wake);
	modport ctl_mp  (output set, clr, ue, en, err_en, stop, sleep, wake_ok,
			 input flags, irq, wake);
endinterface : uic_evt_if
`default_nettype wire

// ==== rtl/uic_flags.sv ====
/*
 * sticky event flags of the transceiver.
 * assumes set pulses come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module uic_flags
	import uic_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// carrier
	uic_evt_if.flag_mp ev
);
	logic [14:0] flags_r;
	logic [14:0] flags_nxt;

	always_comb begin
		if (!ev.ue) begin
			flags_nxt = FLAG_DEFAULT;
		end else begin
			flags_nxt = (flags_r & ~ev.clr) | ev.set;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_r <= FLAG_DEFAULT;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign ev.flags = flags_r;

	chk_set_wins_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ev.ue && ev.set[F_RX_NOT_EMPTY_FLAG] && ev.clr[F_RX_NOT_EMPTY_FLAG]) |=> flags_r[F_RX_NOT_EMPTY_FLAG])
		else $error("flag set lost against clear");
endmodule : uic_flags
`default_nettype wire

// ==== rtl/uic_irq.sv ====
/*
 * gates each flag with its enable and merges onto one interrupt level.
 * assumes enables and power state come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module uic_irq
	import uic_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// carrier
	uic_evt_if.irq_mp ev
);
	logic [14:0] req;
	logic        err_req;
	logic        any_req;
	logic        stop_req;
	logic        irq_r;
	logic        wake_r;

	genvar i;
	generate
		for (i = 0; i < NFLAG; i++) begin : g_gate
			if (i == F_WUF) begin : g_wuf
				assign req[i] = ev.flags[i] & ev.en[i] & ev.stop;
			end else begin : g_std
				assign req[i] = ev.flags[i] & ev.en[i];
			end
		end
	endgenerate

	assign err_req  = ev.err_en & (|(ev.flags & FLAG_ERR_MASK));
	assign any_req  = (|req) | err_req;
	assign stop_req = ev.wake_ok & (req[F_RX_NOT_EMPTY_FLAG] | req[F_WUF]);

	// level interrupt and wakeup request
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= any_req;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_r <= 1'b0;
		end else if (ev.stop) begin
			wake_r <= stop_req;
		end else begin
			wake_r <= ev.sleep & any_req;
		end
	end

	assign ev.irq  = irq_r;
	assign ev.wake = wake_r;

	chk_sleep_wakes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ev.sleep && !ev.stop && any_req) |=> (ev.wake && ev.irq))
		else $error("sleep not left on interrupt");
endmodule : uic_irq
`default_nettype wire

// ==== test/uic_pwr_model.sv ====
/*
 * power and interrupt controller model facing uic_ctrl.
 * assumes the bench sends power commands on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module uic_pwr_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// bench command: 1 sleep, 2 stop
	input  wire logic [1:0] cmd_i,
	// from block
	input  wire logic       irq_i,
	input  wire logic       wake_i,
	// power state to block
	output logic            sleep_o,
	output logic            stop_o
);
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleep_o <= 1'b0;
			stop_o  <= 1'b0;
		end else if (cmd_i == 2'h1) begin
			sleep_o <= 1'b1;
		end else if (cmd_i == 2'h2) begin
			stop_o <= 1'b1;
		end else if (sleep_o && (irq_i || wake_i)) begin
			sleep_o <= 1'b0;
		end else if (stop_o && wake_i) begin
			stop_o <= 1'b0;
		end
	end
endmodule : uic_pwr_model
`default_nettype wire

// ==== test/uic_ctrl_bench.sv ====
/*
 * self-checking bench of uic_ctrl with the power controller model.
 * assumes uic_pkg and the design files are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`define CMP(nm, e, o) begin tests_run++; if ((o) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", nm, e, o); end end
module uic_ctrl_bench;
	import uic_pkg::*;
	typedef struct {int kind; logic [31:0] exp;} uic_note_t;
	logic        clk_i = 0, rst_n_i = 0, rd_q = 0, wr_q = 0, probe = 0;
	logic        irq_o, wake_o, slp, stp, wait_o;
	logic [5:0]  addr = '0;
	logic [31:0] wdata = '0, rdata, obs;
	logic [14:0] evt = '0;
	logic [1:0]  kclk = '0, pcmd = '0;
	logic [3:0]  dbits;
	logic [2:0]  en_o;
	int          err_total = 0, tests_run = 0;
	uic_note_t   notes[$];
	string       kname[6] = '{"readdata", "irq", "wake", "data_bits", "power", "enables"};
	logic [1:0]  wl[4] = '{WLEN_8, WLEN_9, WLEN_7, 2'h3};
	logic [3:0]  db[4] = '{DBITS_8, DBITS_9, DBITS_7, DBITS_8};
	int          sf[14] = '{F_PE, F_FE, F_NF, F_ORE, F_ORE, F_IDLE, F_RX_NOT_EMPTY_FLAG, F_TC, F_TXE,
		F_CTS, F_RTO, F_EOB, F_CM, F_COMPLETE_BEFORE_GUARD_FLAG};
	logic [5:0]  so[14] = '{6'h00, 6'h08, 6'h08, 6'h08, 6'h00, 6'h00, 6'h00, 6'h00,
		6'h00, 6'h08, 6'h00, 6'h00, 6'h00, 6'h08};
	int          sb[14] = '{B_PARITY_ERROR_IRQ_ENABLE, B_EIE, B_EIE, B_EIE, B_RXIE, B_IDLE_LINE_IRQ_ENABLE, B_RXIE, B_TRANSFER_COMPLETE_IRQ_ENABLE,
		B_TX_EMPTY_IRQ_ENABLE, B_CLEAR_TO_SEND_IRQ_ENABLE, B_RX_TIMEOUT_IRQ_ENABLE, B_END_OF_BLOCK_IRQ_ENABLE, B_CHAR_MATCH_IRQ_ENABLE, B_COMPLETE_BEFORE_GUARD_IRQ_ENABLE};

	always #4 clk_i = ~clk_i;

	uic_ctrl dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr),
		.avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
		.evt_set_i(evt), .sleep_i(slp), .stop_i(stp), .kclk_sel_i(kclk),
		.unit_enable_o(en_o[0]), .tx_enable_o(en_o[2]), .rx_enable_o(en_o[1]),
		.data_bits_o(dbits),
		.irq_o(irq_o), .wake_req_o(wake_o));

	uic_pwr_model pwr_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(pcmd), .irq_i(irq_o),
		.wake_i(wake_o), .sleep_o(slp), .stop_o(stp));

	// result watcher: oldest note against what is seen
	always @(negedge clk_i) begin
		if (probe || (rd_q && wait_o === 1'b0)) begin
			case (notes[0].kind)
				0: obs = rdata;
				1: obs = {31'h0, irq_o};
				2: obs = {31'h0, wake_o};
				3: obs = {28'h0, dbits};
				5: obs = {29'h0, en_o};
				default: obs = {30'h0, slp, stp};
			endcase
			`CMP(kname[notes[0].kind], notes[0].exp, obs)
			void'(notes.pop_front());
		end
	end

	task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wr_q  <= w;
		rd_q  <= !w;
		addr  <= a;
		wdata <= d;
		do @(negedge clk_i); while (wait_o !== 1'b0 && ++n < 20);
		if (n >= 20) err_total++;
		@(posedge clk_i);
		wr_q <= 1'b0;
		rd_q <= 1'b0;
	endtask : bus

	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		notes.push_back('{0, e});
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic look(input int k, input logic [31:0] e);
		notes.push_back('{k, e});
		@(posedge clk_i);
		probe <= 1'b1;
		@(posedge clk_i);
		probe <= 1'b0;
	endtask : look

	task automatic pulse(input int b);
		@(posedge clk_i);
		evt <= 15'(1) << b;
		@(posedge clk_i);
		evt <= '0;
	endtask : pulse

	task automatic power(input logic [1:0] v);
		@(posedge clk_i);
		pcmd <= v;
		@(posedge clk_i);
		pcmd <= 2'h0;
	endtask : power

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		end_sim;
	end

	initial begin
		void'($urandom(32'h9452));
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(OFS_CONTROL_ONE, CONTROL_ONE_RESET);
		rd(OFS_STATUS, {17'h0, FLAG_DEFAULT});
		bus(1'b1, 6'h3C, $urandom());
		rd(6'h3C, 32'h0);
		foreach (wl[i]) begin
			bus(1'b1, OFS_CONTROL_ONE, (32'(wl[i][1]) << B_M1) | (32'(wl[i][0]) << B_M0));
			look(3, {28'h0, db[i]});
		end
		bus(1'b1, OFS_CONTROL_ONE, 32'hF000_0001);
		rd(OFS_CONTROL_ONE, 32'h1000_0001);
		bus(1'b1, OFS_CONTROL_ONE, 32'h0000_0001);
		rd(OFS_CONTROL_ONE, 32'h1000_0001);
		look(3, {28'h0, DBITS_7});
		bus(1'b1, OFS_FLAG_CLR, 32'h7FFF);
		for (int i = 0; i < 14; i++) begin
			bus(1'b1, so[i], (32'h1 << sb[i]) | 32'(so[i] == OFS_CONTROL_ONE));
			pulse(sf[i]);
			repeat (2) look(1, 32'h1);
			bus(1'b1, OFS_FLAG_CLR, 32'h1 << sf[i]);
			look(1, 32'h0);
			bus(1'b1, so[i], 32'(so[i] == OFS_CONTROL_ONE));
			pulse(sf[i]);
			look(1, 32'h0);
			bus(1'b1, OFS_FLAG_CLR, 32'h7FFF);
		end
		pulse(F_PE);
		rd(OFS_STATUS, 32'h0000_0001);
		bus(1'b1, OFS_CONTROL_ONE, 32'h1000_0000);
		pulse(F_PE);
		rd(OFS_STATUS, {17'h0, FLAG_DEFAULT});
		rd(OFS_CONTROL_ONE, 32'h1000_0000);
		bus(1'b1, OFS_CONTROL_ONE, 32'h1000_0023);
		bus(1'b1, OFS_FLAG_CLR, 32'h7FFF);
		power(2'h2);
		pulse(F_RX_NOT_EMPTY_FLAG);
		look(2, 32'h0);
		look(4, 32'h1);
		bus(1'b1, OFS_FLAG_CLR, 32'h20);
		kclk <= KCLK_FAST_OSC | 2'($urandom_range(1));
		pulse(F_RX_NOT_EMPTY_FLAG);
		repeat (3) @(posedge clk_i);
		look(4, 32'h0);
		bus(1'b1, OFS_FLAG_CLR, 32'h7FFF);
		bus(1'b1, OFS_IRQ_CTRL, 32'h1 << B_WAKEUP_IRQ_ENABLE);
		pulse(F_WUF);
		look(1, 32'h0);
		power(2'h2);
		repeat (3) @(posedge clk_i);
		look(4, 32'h0);
		bus(1'b1, OFS_FLAG_CLR, 32'h7FFF);
		power(2'h1);
		look(4, 32'h2);
		pulse(F_RX_NOT_EMPTY_FLAG);
		repeat (3) @(posedge clk_i);
		look(4, 32'h0);
		// standby: power lost, software sets up control_one again
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(OFS_CONTROL_ONE, CONTROL_ONE_RESET);
		look(5, 32'h0);
		bus(1'b1, OFS_CONTROL_ONE, 32'h0000_000D);
		rd(OFS_CONTROL_ONE, 32'h0000_000D);
		look(5, 32'h7);
		bus(1'b1, OFS_CONTROL_ONE, 32'h0000_000C);
		look(5, 32'h0);
		rd(OFS_CONTROL_ONE, 32'h0000_000C);
		end_sim;
	end
endmodule : uic_ctrl_bench
`default_nettype wire
